// [ssr_pkg.sv]
// package of constants and types for the status reporting block
package ssr_pkg;
  localparam int NUM_CH = 3;
  localparam int ERR_DEPTH = 8;
  localparam int ERR_AW = 3;
  localparam int ERR_W = 16;
  // questionable and summary bit positions
  localparam int QB_CC = 0;
  localparam int QB_CV = 1;
  localparam int QB_OTEMP = 4;
  localparam int QB_OVP = 9;
  localparam int QB_FUSE = 10;
  localparam logic [15:0] Q_USED_MASK = 16'h0613;
  localparam logic [15:0] SUM_USED_MASK = 16'h0003;
  // event status bits and status byte bits
  localparam int ESR_OPC = 0;
  localparam int STB_QUES = 3;
  localparam int STB_ESB = 5;
  localparam int STB_RQS = 6;
  localparam logic [7:0] SRE_RQS_MASK = 8'hBF;
  localparam logic [15:0] RST_16 = 16'h0000;
  localparam logic [7:0] RST_8 = 8'h00;
  // command codes
  typedef enum logic [3:0] {
    SSR_CMD_NOP      = 4'h0,
    SSR_CMD_OPC      = 4'h1,
    SSR_CMD_OPCQ     = 4'h2,
    SSR_CMD_WAI      = 4'h3,
    SSR_CMD_ESE_WR   = 4'h4,
    SSR_CMD_ESE_RD   = 4'h5,
    SSR_CMD_ESR_RD   = 4'h6,
    SSR_CMD_STB_RD   = 4'h7,
    SSR_CMD_SRE_WR   = 4'h8,
    SSR_CMD_QCOND_RD = 4'h9,
    SSR_CMD_QEVT_RD  = 4'hA,
    SSR_CMD_QENA_WR  = 4'hB,
    SSR_CMD_SCOND_RD = 4'hC,
    SSR_CMD_SEVT_RD  = 4'hD,
    SSR_CMD_ERR_RD   = 4'hE,
    SSR_CMD_CLS      = 4'hF
  } ssr_cmd_t;
  typedef enum logic [1:0] {
    SSR_IDLE = 2'b00,
    SSR_EXEC = 2'b01,
    SSR_DRAIN = 2'b10
  } ssr_state_t;
endpackage

// [ssr_err_mem.sv]
// small error queue storage with registered read data
`timescale 1ns/1ps
module ssr_err_mem
  import ssr_pkg::*;
(
  // clock
  input  wire logic              core_clk_in,
  // write port
  input  wire logic              wr_en_in,
  input  wire logic [ERR_AW-1:0] wr_addr_in,
  input  wire logic [ERR_W-1:0]  wr_data_in,
  // read port
  input  wire logic [ERR_AW-1:0] rd_addr_in,
  output logic      [ERR_W-1:0]  rd_data_out
);
  logic [ERR_W-1:0] mem [ERR_DEPTH];

  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    rd_data_out <= mem[rd_addr_in];
  end
endmodule

// [ssr_status_set.sv]
// one condition/event/enable status register set
`timescale 1ns/1ps
module ssr_status_set
  import ssr_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  // condition input and controls
  input  wire logic [15:0] cond_in,
  input  wire logic [15:0] used_mask_in,
  input  wire logic        evt_clr_in,
  input  wire logic        ena_wr_in,
  input  wire logic [15:0] ena_data_in,
  // register views
  output logic      [15:0] cond_out,
  output logic      [15:0] evt_out,
  output logic      [15:0] ena_out,
  output logic             summary_out
);
  logic [15:0] cond_ff;
  logic [15:0] evt_ff;
  logic [15:0] ena_ff;
  logic [15:0] masked_cond;
  logic [15:0] rise;

  // bit 15 and unused bits are forced to zero in every part
  assign masked_cond = cond_in & used_mask_in & 16'h7FFF;
  assign rise = masked_cond & ~cond_ff;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cond_ff <= RST_16;
    end else begin
      cond_ff <= masked_cond;
    end
  end

  // rising edge sets win over the read clear
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      evt_ff <= RST_16;
    end else if (evt_clr_in) begin
      evt_ff <= rise;
    end else begin
      evt_ff <= evt_ff | rise;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ena_ff <= RST_16;
    end else if (ena_wr_in) begin
      ena_ff <= ena_data_in & used_mask_in & 16'h7FFF;
    end
  end

  assign cond_out = cond_ff;
  assign evt_out = evt_ff;
  assign ena_out = ena_ff;
  assign summary_out = |(evt_ff & ena_ff);
endmodule

// [ssr_status_top.sv]
// status reporting and command synchronisation top
`timescale 1ns/1ps
module ssr_status_top
  import ssr_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              nrst_in,
  // command port
  input  wire logic              cmd_valid_in,
  input  wire logic [3:0]        cmd_code_in,
  input  wire logic [1:0]        cmd_chan_in,
  input  wire logic [15:0]       cmd_data_in,
  output logic                   cmd_ready_out,
  // answer port
  output logic                   resp_valid_out,
  output logic [15:0]            resp_data_out,
  output logic                   resp_no_error_out,
  // instrument execution engine
  output logic                   exec_start_out,
  input  wire logic              exec_done_in,
  // hardware status
  input  wire logic [NUM_CH-1:0] constant_current_mode_in,
  input  wire logic [NUM_CH-1:0] constant_voltage_mode_in,
  input  wire logic              over_temp_in,
  input  wire logic              overvoltage_protection_in,
  input  wire logic              fuse_trip_in,
  // error reporting
  input  wire logic              err_push_in,
  input  wire logic [ERR_W-1:0]  err_code_in,
  // service request pin, active low
  output logic                   srq_n_out
);
  ssr_state_t state_ff;
  ssr_state_t nxt_state;
  logic [7:0] esr_ff;
  logic [7:0] ese_ff;
  logic [7:0] sre_ff;
  logic       esr_rise_ff;
  logic       cmd_ready_ff;
  logic       resp_valid_ff;
  logic [15:0] resp_data_ff;
  logic       resp_noerr_ff;
  logic       exec_start_ff;
  logic       srq_n_ff;
  logic       pend_opcq_ff;
  logic       pend_opc_ff;
  logic       pend_err_ff;
  logic [ERR_AW-1:0] wr_ptr_ff;
  logic [ERR_AW-1:0] rd_ptr_ff;
  logic [ERR_AW:0]   err_cnt_ff;
  logic [ERR_W-1:0]  err_rd_data;
  logic       take;
  logic       cmd_is_local;
  logic       q_evt_clr;
  logic       q_ena_wr;
  logic       q_sum;
  logic [15:0] q_cond;
  logic [15:0] q_evt;
  logic [15:0] q_cond_in;
  logic [15:0] s_cond [NUM_CH];
  logic [15:0] s_evt [NUM_CH];
  logic       err_empty_ff;
  logic [NUM_CH-1:0] s_clr;
  logic [7:0] stb;
  logic [7:0] nxt_esr;
  logic       err_pop;
  logic       err_push_ok;

  // decodes a command code into a locally handled register access
  function automatic logic is_local(input logic [3:0] code);
    is_local = (code != SSR_CMD_NOP) && (code != SSR_CMD_OPC) && (code != SSR_CMD_OPCQ) &&
               (code != SSR_CMD_WAI);
  endfunction

  assign take = cmd_valid_in && cmd_ready_ff;
  assign cmd_is_local = is_local(cmd_code_in);

  // questionable condition assembled from hardware status
  always_comb begin
    q_cond_in = RST_16;
    q_cond_in[QB_CC] = |constant_current_mode_in;
    q_cond_in[QB_CV] = |constant_voltage_mode_in;
    q_cond_in[QB_OTEMP] = over_temp_in;
    q_cond_in[QB_OVP] = overvoltage_protection_in;
    q_cond_in[QB_FUSE] = fuse_trip_in;
  end

  assign q_evt_clr = take && (cmd_code_in == SSR_CMD_QEVT_RD);
  assign q_ena_wr = take && (cmd_code_in == SSR_CMD_QENA_WR);

  ssr_status_set u_ques (
    .core_clk_in  (core_clk_in),
    .nrst_in      (nrst_in),
    .cond_in      (q_cond_in),
    .used_mask_in (Q_USED_MASK),
    .evt_clr_in   (q_evt_clr),
    .ena_wr_in    (q_ena_wr),
    .ena_data_in  (cmd_data_in),
    .cond_out     (q_cond),
    .evt_out      (q_evt),
    .ena_out      (),
    .summary_out  (q_sum)
  );

  // one summary set per channel; enables stay zero, no command writes them
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
      assign s_clr[gi] = take && (cmd_code_in == SSR_CMD_SEVT_RD) &&
                         (cmd_chan_in == 2'(gi + 1));
      ssr_status_set u_sum (
        .core_clk_in  (core_clk_in),
        .nrst_in      (nrst_in),
        .cond_in      ({14'h0000, constant_voltage_mode_in[gi],
                        constant_current_mode_in[gi]}),
        .used_mask_in (SUM_USED_MASK),
        .evt_clr_in   (s_clr[gi]),
        .ena_wr_in    (1'b0),
        .ena_data_in  (RST_16),
        .cond_out     (s_cond[gi]),
        .evt_out      (s_evt[gi]),
        .ena_out      (),
        .summary_out  ()
      );
    end
  endgenerate

  // status byte built live from summaries
  always_comb begin
    stb = RST_8;
    stb[STB_QUES] = q_sum;
    stb[STB_ESB] = |(esr_ff & ese_ff);
    stb[STB_RQS] = |(stb & sre_ff & SRE_RQS_MASK);
  end

  // sequencer: one command at a time, completion waits hold new ones
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SSR_IDLE: begin
        if (take && !cmd_is_local && (cmd_code_in != SSR_CMD_NOP)) begin
          nxt_state = SSR_EXEC;
        end
      end
      SSR_EXEC: begin
        if (exec_done_in) begin
          nxt_state = SSR_DRAIN;
        end
      end
      SSR_DRAIN: nxt_state = SSR_IDLE;
      default: nxt_state = SSR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= SSR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ready drops while the engine runs a prior command
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_ready_ff <= 1'b0;
      exec_start_ff <= 1'b0;
    end else begin
      cmd_ready_ff <= (nxt_state == SSR_IDLE) && !take;
      exec_start_ff <= (state_ff == SSR_IDLE) && (nxt_state == SSR_EXEC);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_opc_ff <= 1'b0;
      pend_opcq_ff <= 1'b0;
    end else if (take) begin
      pend_opc_ff <= (cmd_code_in == SSR_CMD_OPC);
      pend_opcq_ff <= (cmd_code_in == SSR_CMD_OPCQ);
    end else if (state_ff == SSR_DRAIN) begin
      pend_opc_ff <= 1'b0;
      pend_opcq_ff <= 1'b0;
    end
  end

  // event status register: completion set wins over read clear
  always_comb begin
    nxt_esr = esr_ff;
    if (take && (cmd_code_in == SSR_CMD_ESR_RD)) begin
      nxt_esr = RST_8;
    end
    if ((state_ff == SSR_DRAIN) && (pend_opc_ff || pend_opcq_ff)) begin
      nxt_esr[ESR_OPC] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      esr_ff <= RST_8;
      esr_rise_ff <= 1'b0;
    end else begin
      esr_ff <= nxt_esr;
      esr_rise_ff <= |(nxt_esr & ~esr_ff & ese_ff);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ese_ff <= RST_8;
      sre_ff <= RST_8;
    end else if (take) begin
      if (cmd_code_in == SSR_CMD_ESE_WR) begin
        ese_ff <= cmd_data_in[7:0];
      end
      if (cmd_code_in == SSR_CMD_SRE_WR) begin
        sre_ff <= cmd_data_in[7:0] & SRE_RQS_MASK;
      end
    end
  end

  // error queue pointers; a push into a full queue is dropped unless an error read pops in the same cycle
  assign err_pop = take && (cmd_code_in == SSR_CMD_ERR_RD) && (err_cnt_ff != '0);
  assign err_push_ok = err_push_in && (err_cnt_ff != (ERR_AW + 1)'(ERR_DEPTH) || err_pop);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      err_cnt_ff <= '0;
    end else begin
      if (err_push_ok) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (err_pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (err_push_ok && !err_pop) begin
        err_cnt_ff <= err_cnt_ff + 1'b1;
      end else if (!err_push_ok && err_pop) begin
        err_cnt_ff <= err_cnt_ff - 1'b1;
      end
    end
  end

  ssr_err_mem u_err (
    .core_clk_in (core_clk_in),
    .wr_en_in    (err_push_ok),
    .wr_addr_in  (wr_ptr_ff),
    .wr_data_in  (err_code_in),
    .rd_addr_in  (rd_ptr_ff),
    .rd_data_out (err_rd_data)
  );

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_err_ff <= 1'b0;
      err_empty_ff <= 1'b0;
    end else begin
      pend_err_ff <= take && (cmd_code_in == SSR_CMD_ERR_RD);
      // queue state as it stood at the read request, before the pop
      err_empty_ff <= (err_cnt_ff == '0);
    end
  end

  // answers: register words as plain binary, weights summed by value
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      resp_valid_ff <= 1'b0;
      resp_data_ff <= RST_16;
      resp_noerr_ff <= 1'b0;
    end else begin
      resp_valid_ff <= 1'b0;
      resp_noerr_ff <= 1'b0;
      if (take) begin
        resp_valid_ff <= cmd_is_local && (cmd_code_in != SSR_CMD_ERR_RD) &&
                         (cmd_code_in != SSR_CMD_ESE_WR) && (cmd_code_in != SSR_CMD_SRE_WR) &&
                         (cmd_code_in != SSR_CMD_QENA_WR) && (cmd_code_in != SSR_CMD_CLS);
        case (cmd_code_in)
          SSR_CMD_ESE_RD:   resp_data_ff <= {8'h00, ese_ff};
          SSR_CMD_ESR_RD:   resp_data_ff <= {8'h00, esr_ff};
          SSR_CMD_STB_RD:   resp_data_ff <= {8'h00, stb};
          SSR_CMD_QCOND_RD: resp_data_ff <= q_cond;
          SSR_CMD_QEVT_RD:  resp_data_ff <= q_evt;
          SSR_CMD_SCOND_RD: resp_data_ff <= s_cond[cmd_chan_in - 2'd1];
          SSR_CMD_SEVT_RD:  resp_data_ff <= s_evt[cmd_chan_in - 2'd1];
          default:          resp_data_ff <= resp_data_ff;
        endcase
      end else if (pend_err_ff) begin
        resp_valid_ff <= 1'b1;
        resp_data_ff <= err_empty_ff ? RST_16 : err_rd_data;
        resp_noerr_ff <= err_empty_ff;
      end else if ((state_ff == SSR_DRAIN) && pend_opcq_ff) begin
        resp_valid_ff <= 1'b1;
        resp_data_ff <= 16'h0001;
      end
    end
  end

  // service request pin pulled low while an enabled summary is present
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      srq_n_ff <= 1'b1;
    end else begin
      srq_n_ff <= !(|(stb & sre_ff & SRE_RQS_MASK) || (esr_rise_ff && sre_ff[STB_ESB]));
    end
  end

  assign cmd_ready_out = cmd_ready_ff;
  assign resp_valid_out = resp_valid_ff;
  assign resp_data_out = resp_data_ff;
  assign resp_no_error_out = resp_noerr_ff;
  assign exec_start_out = exec_start_ff;
  assign srq_n_out = srq_n_ff;
endmodule

// [ssr_engine_model.sv]
// behavioural execution engine answering the block's start pulses
`timescale 1ns/1ps
module ssr_engine_model (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  // job control
  input  wire logic       exec_start_in,
  input  wire logic [7:0] delay_in,
  output logic            exec_done_out
);
  logic [7:0] cnt_ff;
  // one job at a time; done pulses delay_in cycles after the edge that samples the start, never for a delay_in of 0
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff        <= 8'h00;
      exec_done_out <= 1'b0;
    end else begin
      exec_done_out <= (cnt_ff == 8'h01);
      if (exec_start_in) cnt_ff <= delay_in;
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule

// [ssr_status_assertions.sv]
// concurrent checks on the status reporting top ports
`timescale 1ns/1ps
module ssr_status_chk
  import ssr_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  // command and answer
  input wire logic        cmd_valid_in,
  input wire logic [3:0]  cmd_code_in,
  input wire logic        cmd_ready_out,
  input wire logic        resp_valid_out,
  input wire logic [15:0] resp_data_out,
  input wire logic        resp_no_error_out,
  // engine and service request
  input wire logic        exec_start_out,
  input wire logic        exec_done_in,
  input wire logic        srq_n_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic       busy_ff;
  logic       opcq_ff;
  logic       tk1_ff;
  logic [3:0] cd1_ff;
  wire        take = cmd_valid_in && cmd_ready_out;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_ff <= 1'b0;
      opcq_ff <= 1'b0;
      tk1_ff  <= 1'b0;
      cd1_ff  <= 4'h0;
    end else begin
      busy_ff <= exec_start_out || (busy_ff && !exec_done_in);
      opcq_ff <= (take && cmd_code_in == SSR_CMD_OPCQ) || (opcq_ff && !exec_done_in);
      tk1_ff  <= take;
      cd1_ff  <= cmd_code_in;
    end
  end
  property p_take_gap;
    take |=> !cmd_ready_out;
  endproperty
  a_take_gap: assert property (p_take_gap) else $error("ready high after take");
  property p_busy;
    busy_ff |-> !cmd_ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("command taken during execution");
  property p_opc_start;
    take && cmd_code_in inside {SSR_CMD_OPC, SSR_CMD_OPCQ, SSR_CMD_WAI}
      |-> ##[1:2] exec_start_out;
  endproperty
  a_opc_start: assert property (p_opc_start) else $error("no engine start");
  property p_opcq;
    opcq_ff && exec_done_in |-> ##[1:3] (resp_valid_out && resp_data_out == 16'h0001);
  endproperty
  a_opcq: assert property (p_opcq) else $error("completion query not 1");
  property p_byte;
    tk1_ff && cd1_ff inside {SSR_CMD_ESR_RD, SSR_CMD_ESE_RD, SSR_CMD_STB_RD}
      |-> ##[0:1] (resp_valid_out && resp_data_out[15:8] == 8'h00);
  endproperty
  a_byte: assert property (p_byte) else $error("byte register answer");
  property p_word;
    tk1_ff && cd1_ff inside {SSR_CMD_QCOND_RD, SSR_CMD_QEVT_RD, SSR_CMD_SCOND_RD,
      SSR_CMD_SEVT_RD} |-> ##[0:1] (resp_valid_out && resp_data_out[15:11] == 5'h00);
  endproperty
  a_word: assert property (p_word) else $error("status word answer");
  property p_err;
    take && cmd_code_in == SSR_CMD_ERR_RD |-> ##[1:3] resp_valid_out;
  endproperty
  a_err: assert property (p_err) else $error("error read unanswered");
  property p_noerr;
    resp_no_error_out |-> resp_valid_out && resp_data_out == 16'h0000;
  endproperty
  a_noerr: assert property (p_noerr) else $error("no-error answer not 0");
  c_opcq: cover property (opcq_ff && exec_done_in);
  c_noerr: cover property (resp_no_error_out);
  c_srq: cover property (!srq_n_out);
endmodule
bind ssr_status_top ssr_status_chk u_chk (
  .core_clk_in       (core_clk_in),
  .nrst_in           (nrst_in),
  .cmd_valid_in      (cmd_valid_in),
  .cmd_code_in       (cmd_code_in),
  .cmd_ready_out     (cmd_ready_out),
  .resp_valid_out    (resp_valid_out),
  .resp_data_out     (resp_data_out),
  .resp_no_error_out (resp_no_error_out),
  .exec_start_out    (exec_start_out),
  .exec_done_in      (exec_done_in),
  .srq_n_out         (srq_n_out)
);

// [scpi_status_reporting_bench.sv]
// self-checking bench for the status reporting top
`timescale 1ns/1ps
module scpi_status_reporting_bench
  import ssr_pkg::*;
;
  logic              core_clk_in = 1'b0;
  logic              nrst_in = 1'b0;
  logic              cmd_valid = 1'b0;
  logic [3:0]        cmd_code = 4'h0;
  logic [1:0]        cmd_chan = 2'h0;
  logic [15:0]       cmd_data = 16'h0000;
  logic [NUM_CH-1:0] cc = 3'h0;
  logic [NUM_CH-1:0] cv = 3'h0;
  logic              ot = 1'b0;
  logic              overvoltage_protection = 1'b0;
  logic              fuse = 1'b0;
  logic              err_push = 1'b0;
  logic [15:0]       err_code = 16'h0000;
  logic [7:0]        eng_dly = 8'h01;
  logic              rdy, rv, noerr, start, done, srq_n;
  logic [15:0]       rdata;
  logic [16:0]       exp_q[$];
  logic [16:0]       mon_e;
  logic [15:0]       ecode[9];
  logic [8:0]        st;
  logic [8:0]        pst = 9'h000;
  int                error_cnt = 0;
  int                checked = 0;

  always #10 core_clk_in = ~core_clk_in;

  ssr_status_top dut (
    .core_clk_in               (core_clk_in),
    .nrst_in                   (nrst_in),
    .cmd_valid_in              (cmd_valid),
    .cmd_code_in               (cmd_code),
    .cmd_chan_in               (cmd_chan),
    .cmd_data_in               (cmd_data),
    .cmd_ready_out             (rdy),
    .resp_valid_out            (rv),
    .resp_data_out             (rdata),
    .resp_no_error_out         (noerr),
    .exec_start_out            (start),
    .exec_done_in              (done),
    .constant_current_mode_in  (cc),
    .constant_voltage_mode_in  (cv),
    .over_temp_in              (ot),
    .overvoltage_protection_in (overvoltage_protection),
    .fuse_trip_in              (fuse),
    .err_push_in               (err_push),
    .err_code_in               (err_code),
    .srq_n_out                 (srq_n)
  );
  ssr_engine_model u_eng (
    .core_clk_in   (core_clk_in),
    .nrst_in       (nrst_in),
    .exec_start_in (start),
    .delay_in      (eng_dly),
    .exec_done_out (done)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hold the command until it is taken, noting the expected answer
  task automatic issue(input ssr_cmd_t c, input logic [1:0] ch, input logic [15:0] d,
                       input logic a, input logic [16:0] e);
    int n;
    n = 0;
    @(posedge core_clk_in);
    cmd_code  <= c;
    cmd_chan  <= ch;
    cmd_data  <= d;
    cmd_valid <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (rdy !== 1'b1 && n < 400);
    if (n >= 400) chk(16'h0001, 16'h0000);
    if (a) exp_q.push_back(e);
    cmd_valid <= 1'b0;
  endtask
  function automatic logic [15:0] qv(input logic [8:0] s);
    return {5'h00, s[8], s[7], 4'h0, s[6], 2'h0, |s[5:3], |s[2:0]};
  endfunction
  function automatic logic [15:0] sv(input logic [8:0] s, input int k);
    return {14'h0000, s[k+2], s[k-1]};
  endfunction

  always @(posedge core_clk_in) begin
    if (rv === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
      else begin
        mon_e = exp_q.pop_front();
        chk(rdata, mon_e[15:0]);
        chk({15'h0000, noerr}, {15'h0000, mon_e[16]});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk_in);
    chk(16'h0001, 16'h0000);
    give_verdict();
  end

  initial begin
    void'($urandom(32'h0000_e940));
    repeat (10) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    issue(SSR_CMD_ESR_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0000);
    issue(SSR_CMD_STB_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0000);
    issue(SSR_CMD_ERR_RD, 2'h0, 16'h0000, 1'b1, 17'h1_0000);
    chk({15'h0000, srq_n}, 16'h0001);
    issue(SSR_CMD_ESE_WR, 2'h0, 16'hff01, 1'b0, 17'h0_0000);
    issue(SSR_CMD_ESE_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0001);
    issue(SSR_CMD_SRE_WR, 2'h0, 16'h0020, 1'b0, 17'h0_0000);
    eng_dly <= 8'h14;
    issue(SSR_CMD_OPC, 2'h0, 16'h0000, 1'b0, 17'h0_0000);
    issue(SSR_CMD_STB_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0060);
    // the request pin follows the summary one edge later
    @(posedge core_clk_in);
    chk({15'h0000, srq_n}, 16'h0000);
    issue(SSR_CMD_ESR_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0001);
    issue(SSR_CMD_ESR_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0000);
    issue(SSR_CMD_STB_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0000);
    chk({15'h0000, srq_n}, 16'h0001);
    issue(SSR_CMD_WAI, 2'h0, 16'h0000, 1'b0, 17'h0_0000);
    issue(SSR_CMD_QCOND_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0000);
    for (int d = 0; d < 2; d++) begin
      eng_dly <= (d == 0) ? 8'h01 : 8'h1e;
      issue(SSR_CMD_OPCQ, 2'h0, 16'h0000, 1'b1, 17'h0_0001);
    end
    // the completion query leaves its flag set; read it away
    issue(SSR_CMD_ESR_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0001);
    for (int i = 0; i < 6; i++) begin
      st = 9'($urandom);
      {fuse, overvoltage_protection, ot, cv, cc} <= st;
      repeat (3) @(posedge core_clk_in);
      issue(SSR_CMD_QCOND_RD, 2'h0, 16'h0000, 1'b1, {1'b0, qv(st)});
      issue(SSR_CMD_QEVT_RD, 2'h0, 16'h0000, 1'b1, {1'b0, qv(st) & ~qv(pst)});
      for (int k = 1; k <= NUM_CH; k++) begin
        issue(SSR_CMD_SCOND_RD, 2'(k), 16'h0000, 1'b1, {1'b0, sv(st, k)});
        issue(SSR_CMD_SEVT_RD, 2'(k), 16'h0000, 1'b1,
              {1'b0, sv(st, k) & ~sv(pst, k)});
      end
      pst = st;
    end
    {fuse, overvoltage_protection, ot, cv, cc} <= 9'h000;
    issue(SSR_CMD_QENA_WR, 2'h0, 16'h0010, 1'b0, 17'h0_0000);
    // temperature bit fell to zero first, so its rise is always an event
    ot <= 1'b1;
    issue(SSR_CMD_STB_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0008);
    issue(SSR_CMD_QEVT_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0010);
    issue(SSR_CMD_STB_RD, 2'h0, 16'h0000, 1'b1, 17'h0_0000);
    for (int i = 0; i < 9; i++) begin
      ecode[i] = 16'h0001 | 16'($urandom);
      err_push <= 1'b1;
      err_code <= ecode[i];
      @(posedge core_clk_in);
    end
    err_push <= 1'b0;
    for (int i = 0; i < ERR_DEPTH; i++)
      issue(SSR_CMD_ERR_RD, 2'h0, 16'h0000, 1'b1, {1'b0, ecode[i]});
    issue(SSR_CMD_ERR_RD, 2'h0, 16'h0000, 1'b1, 17'h1_0000);
    repeat (6) @(posedge core_clk_in);
    chk(16'(exp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule
